/* File: pkg/mid_pkg.sv */
// Constants, encodings and register map of the miscellaneous instruction decoder
package mid_pkg;

   // ----------------------------------------------------------------
   // Instruction word layout
   // ----------------------------------------------------------------
   localparam int INSTR_W = 48;
   localparam int OP_MSB = 47;
   localparam int OP_LSB = 40;
   localparam int SUB_MSB = 39;
   localparam int SUB_LSB = 32;
   localparam int GRP_MSB = 47;
   localparam int GRP_LSB = 45;
   localparam logic [7:0] OP_WAIT = 8'h00;
   localparam logic [7:0] OP_COMPUTE = 8'h01;
   localparam logic [7:0] OP_MODIFY = 8'h16;
   localparam logic [7:0] OP_STACK = 8'h17;
   localparam logic [7:0] OP_CALL = 8'h18;
   localparam logic [7:0] OP_RESTORE = 8'h19;
   localparam logic [2:0] GRP_COMPUTE_MOVE = 3'h1;
   localparam logic [7:0] SUB_CALL_DIRECT = 8'h04;
   localparam logic [7:0] SUB_CALL_REL = 8'h44;
   localparam logic [7:0] SUB_RESTORE = 8'h00;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int LOOP_STACK_PUSH_BIT = 39;
   localparam int LOOP_STACK_POP_BIT = 38;
   localparam int STATUS_STACK_PUSH_BIT = 37;
   localparam int STATUS_STACK_POP_BIT = 36;
   localparam int PC_STACK_PUSH_BIT = 35;
   localparam int PC_STACK_POP_BIT = 34;
   localparam int CACHE_FLUSH_BIT = 33;
   localparam int MOD_BITREV_BIT = 39;
   localparam int MOD_GEN_BIT = 38;
   localparam int MOD_IDX_MSB = 34;
   localparam int MOD_IDX_LSB = 32;
   localparam int MOD_DATA_W = 32;
   localparam int WAIT_BIT = 39;
   localparam int WAIT_MSB = 39;
   localparam int WAIT_LSB = 37;
   localparam logic [2:0] WAIT_DEEP = 3'h5;
   localparam int DELAYED_BRANCH_MODIFIER_BIT = 26;
   localparam int ADDR_W = 24;
   localparam int CMP_W = 23;
   localparam int CU_MSB = 21;
   localparam int CU_LSB = 20;
   localparam logic [1:0] CU_ALU = 2'h0;
   localparam logic [1:0] CU_MUL = 2'h1;
   localparam logic [1:0] CU_SHF = 2'h2;

   // ----------------------------------------------------------------
   // Deep sleep timing
   // ----------------------------------------------------------------
   localparam int DEEP_DIV = 16;
   localparam int DIV_W = 4;
   localparam logic [3:0] DIV_LAST = 4'(DEEP_DIV - 1);
   localparam logic [3:0] MEM_EXTRA_WAIT = 4'hF;
   localparam int EXT_IRQ_N = 3;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int PADDR_W = 12;
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam int CTRL_EN_BIT = 0;
   localparam logic [31:0] CTRL_RST = 32'h0000_0001;
   localparam int ST_STATE_LSB = 0;
   localparam int ST_HBR_BIT = 2;

   typedef enum logic [1:0] {
      MID_RUN = 2'b00,
      MID_IDLE = 2'b01,
      MID_DEEP = 2'b10
   } mid_state_t;

endpackage

/* File: hw/mid_decoder.sv */
// Miscellaneous instruction group decoder and wait control
`timescale 1ns/100ps
module mid_decoder (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Instruction fetch path
   input wire logic instr_vld,
   input wire logic [47:0] instr,
   input wire logic [23:0] cur_pc,
   output logic stall,
   output logic fetch_adv,
   output logic [23:0] resume_pc,
   // Stacks and cache
   output logic loop_push,
   output logic loop_pop,
   output logic sts_push,
   output logic sts_pop,
   output logic pc_push,
   output logic pc_pop,
   output logic cache_flush,
   // Index modify
   output logic imod_vld,
   output logic [3:0] imod_index,
   output logic imod_bitrev,
   output logic [31:0] imod_data,
   // Branch and register transfers
   input wire logic [31:0] i6_val,
   input wire logic [31:0] i7_val,
   output logic jump_vld,
   output logic jump_delayed,
   output logic [23:0] jump_target,
   output logic r2_wr,
   output logic [31:0] r2_data,
   output logic i6_wr,
   output logic [31:0] i6_data,
   output logic i7_wr,
   output logic [31:0] i7_data,
   output logic dm_rd_req,
   output logic [31:0] dm_rd_addr,
   input wire logic dm_rd_vld,
   input wire logic [31:0] dm_rd_data,
   // Compute dispatch
   output logic alu_go,
   output logic mul_go,
   output logic shf_go,
   output logic [22:0] cmp_field,
   // Interrupts and pins
   input wire logic [2:0] external_interrupt_pins_n,
   input wire logic dma_irq,
   input wire logic vector_irq_register,
   input wire logic timer_irq,
   input wire logic core_irq,
   input wire logic host_bus_request_n,
   // Clock rate control
   output logic core_clk_en,
   output logic sport_clk_en,
   output logic [3:0] mem_extra_wait
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [2:0] irq_meta_ff;
   logic [2:0] irq_sync_ff;
   logic hbr_meta_ff;
   logic hbr_sync_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_meta_ff <= 3'h7;
         irq_sync_ff <= 3'h7;
         hbr_meta_ff <= 1'b1;
         hbr_sync_ff <= 1'b1;
      end else begin
         irq_meta_ff <= external_interrupt_pins_n;
         irq_sync_ff <= irq_meta_ff;
         hbr_meta_ff <= host_bus_request_n;
         hbr_sync_ff <= hbr_meta_ff;
      end
   end

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   mid_pkg::mid_state_t state_ff;
   logic [31:0] ctrl_ff;
   logic take;
   logic [7:0] op;
   logic [7:0] sub;
   logic is_wait;
   logic is_nop;
   logic is_idle;
   logic is_deep;
   logic is_stack;
   logic is_mod;
   logic is_call;
   logic is_rel;
   logic is_restore;
   logic is_compute;
   logic wake_deep;
   logic wake_idle;

   function automatic logic [23:0] rel_target(input logic [23:0] pc,
                                              input logic [23:0] offs);
      rel_target = 24'(pc + offs);
   endfunction

   // Held instructions are refused while waiting; fetch is stalled anyway
   assign take = instr_vld && (state_ff == mid_pkg::MID_RUN) && ctrl_ff[mid_pkg::CTRL_EN_BIT];
   assign op = instr[mid_pkg::OP_MSB:mid_pkg::OP_LSB];
   assign sub = instr[mid_pkg::SUB_MSB:mid_pkg::SUB_LSB];
   assign is_wait = take && (op == mid_pkg::OP_WAIT);
   assign is_deep = is_wait && (instr[mid_pkg::WAIT_MSB:mid_pkg::WAIT_LSB] == mid_pkg::WAIT_DEEP);
   assign is_idle = is_wait && instr[mid_pkg::WAIT_BIT] && !is_deep;
   assign is_nop = is_wait && !instr[mid_pkg::WAIT_BIT];
   assign is_stack = take && (op == mid_pkg::OP_STACK);
   assign is_mod = take && (op == mid_pkg::OP_MODIFY);
   assign is_call = take && (op == mid_pkg::OP_CALL) &&
                    ((sub == mid_pkg::SUB_CALL_DIRECT) || (sub == mid_pkg::SUB_CALL_REL));
   assign is_rel = is_call && (sub == mid_pkg::SUB_CALL_REL);
   assign is_restore = take && (op == mid_pkg::OP_RESTORE) && (sub == mid_pkg::SUB_RESTORE);
   assign is_compute = take && ((instr[mid_pkg::GRP_MSB:mid_pkg::GRP_LSB] ==
                       mid_pkg::GRP_COMPUTE_MOVE) || (op == mid_pkg::OP_COMPUTE));
   // Pins are active low
   assign wake_deep = (~irq_sync_ff != 3'h0) || dma_irq || vector_irq_register ||
                      timer_irq;
   assign wake_idle = wake_deep || core_irq;

   // ----------------------------------------------------------------
   // Wait state machine
   // ----------------------------------------------------------------
   mid_pkg::mid_state_t nxt_state;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         mid_pkg::MID_RUN: begin
            if (is_deep) begin
               nxt_state = mid_pkg::MID_DEEP;
            end else if (is_idle) begin
               nxt_state = mid_pkg::MID_IDLE;
            end
         end
         mid_pkg::MID_IDLE: begin
            if (wake_idle) begin
               nxt_state = mid_pkg::MID_RUN;
            end
         end
         mid_pkg::MID_DEEP: begin
            if (wake_deep) begin
               nxt_state = mid_pkg::MID_RUN;
            end
         end
         default: begin
            nxt_state = mid_pkg::MID_RUN;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= mid_pkg::MID_RUN;
         stall <= 1'b0;
         resume_pc <= 24'h00_0000;
      end else begin
         state_ff <= nxt_state;
         stall <= (nxt_state != mid_pkg::MID_RUN);
         if (is_idle || is_deep) begin
            resume_pc <= 24'(cur_pc + 24'h00_0001);
         end
      end
   end

   // ----------------------------------------------------------------
   // Clock divider for deep sleep
   // ----------------------------------------------------------------
   logic [3:0] div_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_ff <= 4'h0;
         core_clk_en <= 1'b1;
         sport_clk_en <= 1'b1;
         mem_extra_wait <= 4'h0;
      end else begin
         if (nxt_state == mid_pkg::MID_DEEP) begin
            div_ff <= (div_ff == mid_pkg::DIV_LAST) ? 4'h0 : 4'(div_ff + 4'h1);
            core_clk_en <= (div_ff == mid_pkg::DIV_LAST);
            sport_clk_en <= (div_ff == mid_pkg::DIV_LAST);
            mem_extra_wait <= mid_pkg::MEM_EXTRA_WAIT;
         end else begin
            div_ff <= 4'h0;
            core_clk_en <= 1'b1;
            sport_clk_en <= 1'b1;
            mem_extra_wait <= 4'h0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Stacks, cache and index modify
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loop_push <= 1'b0;
         loop_pop <= 1'b0;
         sts_push <= 1'b0;
         sts_pop <= 1'b0;
         pc_push <= 1'b0;
         pc_pop <= 1'b0;
         cache_flush <= 1'b0;
      end else begin
         // Each bit is independent so any mix is honoured
         loop_push <= is_stack && instr[mid_pkg::LOOP_STACK_PUSH_BIT];
         loop_pop <= is_stack && instr[mid_pkg::LOOP_STACK_POP_BIT];
         sts_push <= is_stack && instr[mid_pkg::STATUS_STACK_PUSH_BIT];
         sts_pop <= is_stack && instr[mid_pkg::STATUS_STACK_POP_BIT];
         pc_push <= is_stack && instr[mid_pkg::PC_STACK_PUSH_BIT];
         pc_pop <= is_stack && instr[mid_pkg::PC_STACK_POP_BIT];
         // One-cycle pulse; the cache clears in that same cycle
         cache_flush <= is_stack && instr[mid_pkg::CACHE_FLUSH_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         imod_vld <= 1'b0;
         imod_index <= 4'h0;
         imod_bitrev <= 1'b0;
         imod_data <= 32'h0000_0000;
      end else begin
         imod_vld <= is_mod;
         if (is_mod) begin
            imod_index <= {instr[mid_pkg::MOD_GEN_BIT],
                           instr[mid_pkg::MOD_IDX_MSB:mid_pkg::MOD_IDX_LSB]};
            imod_bitrev <= instr[mid_pkg::MOD_BITREV_BIT];
            imod_data <= instr[mid_pkg::MOD_DATA_W-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Calls, frame restore and fetch advance
   // ----------------------------------------------------------------
   logic rst_pend_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         jump_vld <= 1'b0;
         jump_delayed <= 1'b0;
         jump_target <= 24'h00_0000;
         fetch_adv <= 1'b0;
      end else begin
         jump_vld <= is_call;
         fetch_adv <= take && !is_call;
         if (is_call) begin
            jump_delayed <= instr[mid_pkg::DELAYED_BRANCH_MODIFIER_BIT];
            jump_target <= is_rel ? rel_target(cur_pc, instr[mid_pkg::ADDR_W-1:0]) :
                           instr[mid_pkg::ADDR_W-1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r2_wr <= 1'b0;
         r2_data <= 32'h0000_0000;
         i7_wr <= 1'b0;
         i7_data <= 32'h0000_0000;
         dm_rd_req <= 1'b0;
         dm_rd_addr <= 32'h0000_0000;
      end else begin
         r2_wr <= is_call;
         i7_wr <= is_restore;
         dm_rd_req <= is_restore;
         if (is_call) begin
            r2_data <= i6_val;
         end
         if (is_restore) begin
            i7_data <= i6_val;
            dm_rd_addr <= i6_val;
         end
      end
   end

   // Index 6 is written by a call at once, by a restore when the data returns
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         i6_wr <= 1'b0;
         i6_data <= 32'h0000_0000;
         rst_pend_ff <= 1'b0;
      end else begin
         i6_wr <= is_call || (rst_pend_ff && dm_rd_vld);
         if (is_call) begin
            i6_data <= i7_val;
         end else if (rst_pend_ff && dm_rd_vld) begin
            i6_data <= dm_rd_data;
         end
         if (is_restore) begin
            rst_pend_ff <= 1'b1;
         end else if (dm_rd_vld) begin
            rst_pend_ff <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Compute dispatch
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alu_go <= 1'b0;
         mul_go <= 1'b0;
         shf_go <= 1'b0;
         cmp_field <= 23'h00_0000;
      end else begin
         alu_go <= is_compute && (instr[mid_pkg::CU_MSB:mid_pkg::CU_LSB] == mid_pkg::CU_ALU);
         mul_go <= is_compute && (instr[mid_pkg::CU_MSB:mid_pkg::CU_LSB] == mid_pkg::CU_MUL);
         shf_go <= is_compute && (instr[mid_pkg::CU_MSB:mid_pkg::CU_LSB] == mid_pkg::CU_SHF);
         if (is_compute) begin
            cmp_field <= instr[mid_pkg::CMP_W-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // APB registers
   // ----------------------------------------------------------------
   logic setup;
   logic wr_acc;
   logic hbr_err_ff;

   assign setup = psel && !penable;
   assign wr_acc = psel && penable && pwrite;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= mid_pkg::CTRL_RST;
      end else if (wr_acc && (paddr == mid_pkg::ADDR_CTRL)) begin
         ctrl_ff <= pwdata;
      end
   end

   // Host request in deep sleep is a software fault; flag it, set beats clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hbr_err_ff <= 1'b0;
      end else if ((state_ff == mid_pkg::MID_DEEP) && !hbr_sync_ff) begin
         hbr_err_ff <= 1'b1;
      end else if (wr_acc && (paddr == mid_pkg::ADDR_STATUS) && pwdata[mid_pkg::ST_HBR_BIT]) begin
         hbr_err_ff <= 1'b0;
      end
   end

   // Read data captured in setup so the access phase needs no wait
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
         pready <= 1'b0;
      end else begin
         pready <= 1'b1;
         if (setup) begin
            if (paddr == mid_pkg::ADDR_CTRL) begin
               prdata <= ctrl_ff;
               pslverr <= 1'b0;
            end else if (paddr == mid_pkg::ADDR_STATUS) begin
               prdata <= {29'h0000_0000, hbr_err_ff, state_ff};
               pslverr <= 1'b0;
            end else begin
               prdata <= 32'h0000_0000;
               pslverr <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_cache_flush: assert property (is_stack && instr[mid_pkg::CACHE_FLUSH_BIT] |=> cache_flush)
      else $error("flush bit did not pulse cache flush");
   a_flush_once: assert property (cache_flush && !$past(is_stack) |-> 1'b0)
      else $error("cache flush without stack instruction");
   a_loop_mix: assert property (is_stack |=> loop_push == $past(instr[39]) &&
      loop_pop == $past(instr[38]))
      else $error("loop stack strobes wrong");
   a_sts_stack: assert property (is_stack |=> sts_push == $past(instr[37]) &&
      sts_pop == $past(instr[36]))
      else $error("status stack strobes wrong");
   a_pc_stack: assert property (is_stack |=> pc_push == $past(instr[35]) &&
      pc_pop == $past(instr[34]))
      else $error("pc stack strobes wrong");
   a_mod_index: assert property (is_mod |=> imod_vld &&
      imod_index == {$past(instr[38]), $past(instr[34:32])})
      else $error("index select wrong");
   a_nop_quiet: assert property (is_nop |=> fetch_adv && !jump_vld && !r2_wr && !i7_wr
      && !stall)
      else $error("no-op changed state");
   a_idle_hold: assert property (is_idle |=> stall && state_ff == mid_pkg::MID_IDLE)
      else $error("idle did not hold core");
   a_idle_resume: assert property (is_idle |=> resume_pc == 24'($past(cur_pc) + 24'h00_0001))
      else $error("resume address wrong");
   // A wake inside the window brings the enable back high legally
   a_deep_div: assert property (state_ff == mid_pkg::MID_DEEP && core_clk_en &&
      nxt_state == mid_pkg::MID_DEEP |=>
      (!core_clk_en || state_ff != mid_pkg::MID_DEEP) [*8])
      else $error("deep clock not divided");
   a_mem_wait: assert property (state_ff == mid_pkg::MID_DEEP |-> mem_extra_wait == 4'hF)
      else $error("memory wait not fifteen");
   a_sport_div: assert property (state_ff == mid_pkg::MID_DEEP |-> sport_clk_en == core_clk_en)
      else $error("serial clock not divided");
   a_deep_wake: assert property (state_ff == mid_pkg::MID_DEEP && timer_irq |=>
      state_ff == mid_pkg::MID_RUN)
      else $error("deep idle did not end");
   a_call_regs: assert property (is_call |=> r2_wr && r2_data == $past(i6_val) && i6_wr &&
      i6_data == $past(i7_val))
      else $error("call register copies wrong");
   a_rel_target: assert property (is_rel |=> jump_target ==
      24'($past(cur_pc) + $past(instr[23:0])))
      else $error("relative target wrong");
   a_delay_mod: assert property (is_call |=> jump_delayed == $past(instr[26]))
      else $error("delayed branch not honoured");
   a_frame_restore: assert property (is_restore |=> i7_wr && i7_data == $past(i6_val) &&
      dm_rd_req && dm_rd_addr == $past(i6_val))
      else $error("frame restore wrong");
   a_compute_go: assert property (is_compute |=> (alu_go || mul_go || shf_go ||
      $past(instr[21:20]) == 2'h3))
      else $error("compute not dispatched");

   c_idle_wake: cover property (is_idle ##[1:20] state_ff == mid_pkg::MID_RUN);
   c_deep_wake: cover property (is_deep ##[1:100] state_ff == mid_pkg::MID_RUN);
   c_restore: cover property (is_restore ##[1:10] i6_wr);
   c_stack_all: cover property (is_stack && instr[39] && instr[37] && instr[35] && instr[33]);

endmodule // mid_decoder

/* File: sim/mid_core_model.sv */
// Core side model: data memory that answers frame restore loads
`timescale 1ns/100ps
module mid_core_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Data memory read
   input wire logic dm_rd_req,
   input wire logic [31:0] dm_rd_addr,
   input wire logic [3:0] lat,
   output logic dm_rd_vld,
   output logic [31:0] dm_rd_data
);
   logic busy_ff;
   logic [3:0] cnt_ff;
   logic [31:0] addr_ff;
   // Stale data toggles so a late sample never matches by luck
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_ff <= 1'h0;
         cnt_ff <= 4'h0;
         addr_ff <= '0;
         dm_rd_vld <= 1'h0;
         dm_rd_data <= '0;
      end else begin
         dm_rd_vld <= 1'h0;
         dm_rd_data <= ~dm_rd_data;
         if (dm_rd_req) begin
            busy_ff <= 1'h1;
            cnt_ff <= lat;
            addr_ff <= dm_rd_addr;
         end else if (busy_ff && cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
         end else if (busy_ff) begin
            busy_ff <= 1'h0;
            dm_rd_vld <= 1'h1;
            dm_rd_data <= ~addr_ff;
         end
      end
   end
endmodule // mid_core_model

/* File: sim/misc_instruction_decoder_tb.sv */
// Self-checking bench of the miscellaneous instruction decoder
`timescale 1ns/100ps
module misc_instruction_decoder_tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, i6_val = '0, i7_val = '0, dm_rd_data;
   logic pready, pslverr, instr_vld = 0, stall, fetch_adv, er;
   logic [47:0] instr = '0;
   logic [23:0] cur_pc = '0, resume_pc, jump_target, pc, tg;
   logic loop_push, loop_pop, sts_push, sts_pop, pc_push, pc_pop, cache_flush;
   logic imod_vld, imod_bitrev, jump_vld, jump_delayed, r2_wr, i6_wr, i7_wr;
   logic [3:0] imod_index, mem_extra_wait, lat = 4'h1;
   logic [31:0] imod_data, r2_data, i6_data, i7_data, dm_rd_addr, rd, d, x6, x7;
   logic dm_rd_req, dm_rd_vld, alu_go, mul_go, shf_go, core_clk_en, sport_clk_en;
   logic [22:0] cmp_field;
   logic [2:0] external_interrupt_pins_n = 3'h7;
   logic dma_irq = 0, vector_irq_register = 0, timer_irq = 0, core_irq = 0;
   logic host_bus_request_n = 1;
   logic [6:0] sb;
   int bad_count = 0, checks_done = 0, n;
   always #20 pclk = ~pclk;
   mid_decoder dut (.*);
   mid_core_model core (.pclk(pclk), .presetn(presetn), .dm_rd_req(dm_rd_req),
      .dm_rd_addr(dm_rd_addr), .lat(lat), .dm_rd_vld(dm_rd_vld), .dm_rd_data(dm_rd_data));
   task automatic chk(input logic [95:0] g, e);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk) penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic issue(input logic [47:0] i);
      @(posedge pclk);
      pc = 24'($urandom);
      cur_pc <= pc;
      instr <= i;
      instr_vld <= 1'h1;
      @(posedge pclk) instr_vld <= 1'h0;
      #1;
   endtask
   task automatic hold(input logic [4:0] w);
      @(posedge pclk);
      {core_irq, dma_irq, vector_irq_register, timer_irq} <= w[3:0];
      external_interrupt_pins_n <= {2'h3, ~w[4]};
      #1;
      for (n = 0; n < 20 && w != 0 && stall !== 1'h0; n++) @(posedge pclk) #1;
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      #400000;
      bad_count++;
      wrap_up;
   end
   initial begin
      n = $urandom(87);
      repeat (12) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, mid_pkg::ADDR_CTRL, '0);
      chk(rd, mid_pkg::CTRL_RST);
      apb(1'h0, 12'h010, '0);
      chk({er, rd}, {1'h1, 32'h0000_0000});
      apb(1'h1, mid_pkg::ADDR_CTRL, '0);
      issue({mid_pkg::OP_STACK, 40'h7F_0000_0000});
      chk({fetch_adv, loop_push}, 2'h0);
      apb(1'h1, mid_pkg::ADDR_CTRL, 32'h0000_0001);
      $display("test registers done");
      for (int k = 0; k < 30; k++) begin
         sb = (k < 7) ? 7'h40 >> k : 7'($urandom);
         d = $urandom;
         x6 = $urandom;
         x7 = $urandom;
         @(posedge pclk);
         i6_val <= x6;
         i7_val <= x7;
         lat <= sb[3:0];
         issue({mid_pkg::OP_STACK, sb, 33'h0});
         chk({loop_push, loop_pop, sts_push, sts_pop, pc_push, pc_pop, cache_flush,
            fetch_adv}, {sb, 1'h1});
         issue({mid_pkg::OP_MODIFY, sb[1:0], 3'h0, sb[4:2], d});
         chk({imod_vld, imod_bitrev, imod_index, imod_data}, {1'h1, sb[1:0], sb[4:2], d});
         issue({mid_pkg::OP_CALL, sb[0] ? mid_pkg::SUB_CALL_REL : mid_pkg::SUB_CALL_DIRECT,
            5'h0, sb[1], 2'h0, d[23:0]});
         tg = sb[0] ? pc + d[23:0] : d[23:0];
         chk({jump_vld, jump_delayed, jump_target, r2_wr, r2_data, i6_wr, i6_data},
            {1'h1, sb[1], tg, 1'h1, x6, 1'h1, x7});
         issue({mid_pkg::OP_RESTORE, mid_pkg::SUB_RESTORE, 32'h0});
         chk({i7_wr, i7_data, dm_rd_req, dm_rd_addr}, {1'h1, x6, 1'h1, x6});
         for (n = 0; n < 24 && i6_wr !== 1'h1; n++) @(posedge pclk) #1;
         chk({i6_wr, i6_data}, {1'h1, ~x6});
         // Odd passes use the compute opcode, even ones the compute and move group
         issue({k[0] ? mid_pkg::OP_COMPUTE : 8'h3F, 17'h0, d[22], 2'(k % 4), d[19:0]});
         chk({alu_go, mul_go, shf_go, cmp_field},
            {k % 4 == 0, k % 4 == 1, k % 4 == 2, d[22], 2'(k % 4), d[19:0]});
      end
      $display("test decode done");
      issue({mid_pkg::OP_WAIT, 40'h0});
      chk({stall, fetch_adv, jump_vld}, 3'h2);
      issue({mid_pkg::OP_WAIT, 40'h80_0000_0000});
      chk({stall, fetch_adv, resume_pc}, {2'h3, pc + 24'h00_0001});
      hold(5'h08);
      hold(5'h00);
      chk(stall, 1'h0);
      for (int s = 0; s < 4; s++) begin
         issue({mid_pkg::OP_WAIT, 40'hA0_0000_0000});
         chk({stall, mem_extra_wait}, {1'h1, 4'hF});
         n = 0;
         repeat (32) @(posedge pclk) #1 n += core_clk_en + sport_clk_en;
         chk(n, 4);
         apb(1'h0, mid_pkg::ADDR_STATUS, '0);
         chk({er, rd}, 33'h0_0000_0002);
         // Core interrupt alone must not end deep idle
         hold(5'h08);
         chk(stall, 1'h1);
         hold(s == 0 ? 5'h10 : 5'h08 >> s);
         hold(5'h00);
         chk({stall, mem_extra_wait, core_clk_en}, 6'h01);
      end
      $display("test wait done");
      wrap_up;
   end
endmodule // misc_instruction_decoder_tb
